// file: core/scfp_pkg.sv
// Behaviour
// - each data-in bit shifts into a sixteen-bit receive register during the frame
// - serial clock idles low; input sampled on rising, output changed on falling edge
// - data-out is high impedance whenever chip-select is high
// - chip-select held low past the timeout releases data-out to high impedance
// - chip-select low drives data-out at once with the global fault flag
// - on chip-select rise the received word is delivered only after exactly sixteen clocks
// - zero or sixteen clocks accepted; other counts ignored and reported next frame
// - first rising edge loads status into output register; falling edges show next bits
// - in standby the port stays inactive and processes no frames
// - input frame: two-bit opcode, six-bit address, eight-bit payload, msb first
// - output frame: status byte captured at start, payload captured on eighth rising edge
// - timeout or bad clock count sets frame fault and serial error, frame ignored
// - status msb equals nor of status bits 8 to 14
package scfp_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam int          CNT_W          = 5;
  localparam logic [4:0]  CNT_FULL       = 5'h10;  // exactly sixteen rising edges
  localparam logic [4:0]  CNT_PAYLOAD    = 5'h08;  // payload byte loaded on this edge
  localparam logic [4:0]  CNT_MAX        = 5'h1f;  // counter saturates, never wraps to 16
  localparam int          OPC_MSB        = 15;
  localparam int          OPC_LSB        = 14;
  localparam int          ADDR_MSB       = 13;
  localparam int          ADDR_LSB       = 8;
  localparam int          DATA_MSB       = 7;
  localparam int          DATA_LSB       = 0;
  localparam int          GSB_FAULT_NOT  = 7;      // positions within the status byte
  localparam int          GSB_RESET      = 6;
  localparam int          GSB_SER_ERR    = 5;
  localparam int          GSB_RSVD       = 4;
  localparam int          GSB_FUNC_ERR   = 3;
  localparam int          GSB_DEV_ERR    = 2;
  localparam int          GSB_WARN       = 1;
  localparam int          GSB_FAIL_SAFE  = 0;
  localparam logic [7:0]  GSB_RST_VAL    = 8'h80;  // no fault: fault-not bit high
  localparam int          CLK_FREQ_KHZ   = 25000;
  localparam int          CS_TIMEOUT_NS  = 20000;  // plain default; no figure is documented
  localparam int          TIMEOUT_CYCLES = (CS_TIMEOUT_NS * (CLK_FREQ_KHZ / 1000)) / 1000;
endpackage : scfp_pkg

// file: core/scfp_if.sv
`timescale 1ns/10ps
`default_nettype none
// signals shared between the system-clock core and the serial-clock link logic
interface scfp_if;
  import scfp_pkg::*;
  logic [7:0]            status_byte;  // system domain, quasi-static during a frame
  logic [7:0]            payload;      // system domain, quasi-static during a frame
  logic [FRAME_BITS-1:0] rx_word;      // link domain, stable once the clock stops
  logic [CNT_W-1:0]      edge_cnt;     // link domain, stable once the clock stops
  logic                  frame_tog;    // link domain, flips once per clocked frame
  logic                  tx_bit;       // link domain, bit now presented on data-out
  modport link (input status_byte, input payload, output rx_word, output edge_cnt,
                output frame_tog, output tx_bit);
  modport core (output status_byte, output payload, input rx_word, input edge_cnt,
                input frame_tog, input tx_bit);
endinterface : scfp_if
`default_nettype wire

// file: core/scfp_link.sv
`timescale 1ns/10ps
`default_nettype none
module scfp_link
  import scfp_pkg::*;
(
  input  wire logic rst_n_in,
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic sdi_in,
  output var  logic armed_out,
  scfp_if.link      lk
);
  typedef struct packed {
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] tx;
    logic [CNT_W-1:0]      cnt;
    logic                  tog;
  } scfp_link_type;

  scfp_link_type st_r, st_nxt;
  logic          armed_r;
  logic [CNT_W-1:0] ptr_r;

  // armed until the first rising edge; chip-select high re-arms without needing a clock edge
  // reset is needed too: the serial clock is still while reset is held
  always_ff @(posedge sck_in or posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_r <= 1'b1;
    end else if (cs_n_in) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  // rising edge: sample input, count edges, load output word
  always_comb begin
    st_nxt = st_r;
    if (armed_r) begin
      st_nxt.rx  = {{(FRAME_BITS-1){1'b0}}, sdi_in};
      st_nxt.cnt = 5'h01;
      st_nxt.tog = ~st_r.tog;
      st_nxt.tx  = {lk.status_byte, 8'h00};
    end else begin
      st_nxt.rx  = {st_r.rx[FRAME_BITS-2:0], sdi_in};
      st_nxt.cnt = (st_r.cnt == CNT_MAX) ? CNT_MAX : st_r.cnt + 5'h01;
      if (st_nxt.cnt == CNT_PAYLOAD) begin
        st_nxt.tx = {st_r.tx[15:8], lk.payload};
      end
    end
  end

  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // falling edge: advance the output bit pointer; cleared while deselected
  always_ff @(negedge sck_in or posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_r <= '0;
    end else if (cs_n_in) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= st_r.cnt;
    end
  end

  assign lk.tx_bit    = (ptr_r < CNT_FULL) ? st_r.tx[4'hf - ptr_r[3:0]] : 1'b0;
  assign lk.rx_word   = st_r.rx;
  assign lk.edge_cnt  = st_r.cnt;
  assign lk.frame_tog = st_r.tog;
  assign armed_out    = armed_r;
endmodule : scfp_link
`default_nettype wire

// file: core/scfp_port.sv
`timescale 1ns/10ps
`default_nettype none
module scfp_port
  import scfp_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
)(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  sck_in,
  input  wire logic                  cs_n_in,
  input  wire logic                  sdi_in,
  input  wire logic                  standby_in,
  input  wire logic [4:0]            status_in,
  input  wire logic [7:0]            payload_in,
  input  wire logic                  fault_clear_in,
  output logic                       sdo_out,
  output logic                       sdo_oe_n_out,
  output logic                       frame_valid_out,
  output logic [1:0]                 frame_opcode_out,
  output logic [5:0]                 frame_addr_out,
  output logic [7:0]                 frame_data_out,
  output logic                       frame_fault_flag_out,
  output logic                       serial_error_flag_out
);
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_prev;
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_seen;
    logic [15:0] to_cnt;
    logic        timeout;
    logic        ser_err;
    logic        fault;
    logic        valid;
    logic [15:0] word;
    logic [7:0]  global_status_byte;
    logic [7:0]  pay;
  } scfp_core_type;

  scfp_core_type st_r, st_nxt;
  scfp_if        lk_if ();
  logic          armed;

  localparam logic [15:0] TO_LIMIT = 16'(TIMEOUT_CYC);

  scfp_link u_link (
    .rst_n_in  (rst_n_in),
    .sck_in    (sck_in),
    .cs_n_in   (cs_n_in),
    .sdi_in    (sdi_in),
    .armed_out (armed),
    .lk        (lk_if.link)
  );

  // system-clock side: resynchronise, time the select, judge the frame at its end
  always_comb begin
    st_nxt         = st_r;
    st_nxt.valid   = 1'b0;
    st_nxt.cs_s1   = cs_n_in;
    st_nxt.cs_s2   = st_r.cs_s1;
    st_nxt.cs_prev = st_r.cs_s2;
    st_nxt.tog_s1  = lk_if.frame_tog;
    st_nxt.tog_s2  = st_r.tog_s1;
    if (fault_clear_in) begin
      st_nxt.fault = 1'b0;
    end
    if (st_r.cs_s2) begin
      st_nxt.to_cnt  = '0;
      st_nxt.timeout = 1'b0;
    end else if (!st_r.timeout && !standby_in) begin
      st_nxt.to_cnt = st_r.to_cnt + 16'h0001;
      if (st_nxt.to_cnt >= TO_LIMIT) begin
        st_nxt.timeout = 1'b1;
        st_nxt.fault   = 1'b1;                                 // set wins over clear
        st_nxt.ser_err = 1'b1;
      end
    end
    // rising chip-select seen in this domain; timed-out frames stay ignored
    if (st_r.cs_s2 && !st_r.cs_prev && !st_r.timeout && !standby_in) begin
      st_nxt.tog_seen = st_r.tog_s2;
      if (st_r.tog_s2 != st_r.tog_seen) begin
        if (lk_if.edge_cnt == CNT_FULL) begin
          st_nxt.valid   = 1'b1;
          st_nxt.word    = lk_if.rx_word;
          st_nxt.ser_err = 1'b0;
        end else begin
          st_nxt.fault   = 1'b1;
          st_nxt.ser_err = 1'b1;
        end
      end
    end else if (st_r.cs_s2 && !st_r.cs_prev) begin
      st_nxt.tog_seen = st_r.tog_s2;                           // keep toggle history in step
    end
    // status byte refreshed only while deselected so it stays still across a frame
    if (st_r.cs_s2) begin
      st_nxt.global_status_byte[GSB_RESET]     = status_in[4];
      st_nxt.global_status_byte[GSB_SER_ERR]   = st_nxt.ser_err;
      st_nxt.global_status_byte[GSB_RSVD]      = 1'b0;
      st_nxt.global_status_byte[GSB_FUNC_ERR]  = status_in[3];
      st_nxt.global_status_byte[GSB_DEV_ERR]   = status_in[2];
      st_nxt.global_status_byte[GSB_WARN]      = status_in[1];
      st_nxt.global_status_byte[GSB_FAIL_SAFE] = status_in[0];
      st_nxt.global_status_byte[GSB_FAULT_NOT] = ~|st_nxt.global_status_byte[6:0];
      st_nxt.pay                = payload_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r     <= '0;
      st_r.global_status_byte <= GSB_RST_VAL;
      st_r.cs_s1   <= 1'b1;
      st_r.cs_s2   <= 1'b1;
      st_r.cs_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lk_if.status_byte = st_r.global_status_byte;
  assign lk_if.payload     = st_r.pay;

  // data-out must react within half a serial clock, so it cannot wait for the system clock
  assign sdo_out      = armed ? st_r.global_status_byte[GSB_FAULT_NOT] : lk_if.tx_bit;
  assign sdo_oe_n_out = cs_n_in | st_r.timeout | standby_in;

  assign frame_valid_out       = st_r.valid;
  assign frame_opcode_out      = st_r.word[OPC_MSB:OPC_LSB];
  assign frame_addr_out        = st_r.word[ADDR_MSB:ADDR_LSB];
  assign frame_data_out        = st_r.word[DATA_MSB:DATA_LSB];
  assign frame_fault_flag_out  = st_r.fault;
  assign serial_error_flag_out = st_r.ser_err;
endmodule : scfp_port
`default_nettype wire

// file: tb/scfp_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module scfp_assertions
  import scfp_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
)(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       sck_in,
  input wire logic       cs_n_in,
  input wire logic       sdi_in,
  input wire logic       standby_in,
  input wire logic [4:0] status_in,
  input wire logic [7:0] payload_in,
  input wire logic       fault_clear_in,
  input wire logic       sdo_out,
  input wire logic       sdo_oe_n_out,
  input wire logic       frame_valid_out,
  input wire logic [1:0] frame_opcode_out,
  input wire logic [5:0] frame_addr_out,
  input wire logic [7:0] frame_data_out,
  input wire logic       frame_fault_flag_out,
  input wire logic       serial_error_flag_out
);
  logic [15:0] low_cnt_r;  // cycles with chip-select low
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // saturates so a stuck select never wraps back under the limit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_cnt_r <= 16'h0000;
    else if (cs_n_in) low_cnt_r <= 16'h0000;
    else if (low_cnt_r != 16'hffff) low_cnt_r <= low_cnt_r + 16'h0001;
  end
  a_idle_released: assert property (cs_n_in |-> sdo_oe_n_out) else $error("driven while deselected");
  a_timeout_release: assert property ((32'(low_cnt_r) > TIMEOUT_CYC + 4) |-> sdo_oe_n_out)
    else $error("stuck select not released");
  a_status_shown: assert property (($fell(cs_n_in) && !standby_in) |->
    (!sdo_oe_n_out && sdo_out == !(|status_in || serial_error_flag_out))) else $error("fault bit not shown");
  a_valid_late: assert property (frame_valid_out |-> $past(cs_n_in) && $past(cs_n_in, 2) && $past(cs_n_in, 3))
    else $error("word delivered before deselect");
  a_valid_pulse: assert property (frame_valid_out |=> !frame_valid_out) else $error("valid too long");
  a_fields_held: assert property (!frame_valid_out |-> $stable({frame_opcode_out, frame_addr_out, frame_data_out}))
    else $error("fields changed without a frame");
  a_valid_clears: assert property (frame_valid_out |-> ##[0:1] !serial_error_flag_out) else $error("error kept");
  a_error_faults: assert property ($rose(serial_error_flag_out) |-> frame_fault_flag_out) else $error("no fault");
  a_fault_sticky: assert property ((frame_fault_flag_out && !fault_clear_in) |=> frame_fault_flag_out)
    else $error("fault flag dropped");
  a_standby_quiet: assert property ((standby_in && $past(standby_in, 8)) |-> sdo_oe_n_out && !frame_valid_out)
    else $error("active in standby");
  c_valid: cover property (frame_valid_out);
  c_fault: cover property ($rose(frame_fault_flag_out));
  c_timeout: cover property (32'(low_cnt_r) > TIMEOUT_CYC + 4);
endmodule : scfp_assertions
bind scfp_port scfp_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_scfp_assertions (.clk_in, .rst_n_in, .sck_in,
  .cs_n_in, .sdi_in, .standby_in, .status_in, .payload_in, .fault_clear_in, .sdo_out, .sdo_oe_n_out,
  .frame_valid_out, .frame_opcode_out, .frame_addr_out, .frame_data_out, .frame_fault_flag_out,
  .serial_error_flag_out);
`default_nettype wire

// file: tb/scfp_master.sv
`timescale 1ns/10ps
`default_nettype none
module scfp_master (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_n_in
);
  logic        last_r = 1'b0;  // last level read on data-out
  logic [15:0] rd_word;        // bits read back in the last frame
  wire logic   line_w;
  // a released line keeps no level: show the inverse of the last bit
  assign line_w = sdo_oe_n_in ? ~last_r : sdo_in;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // select, clock nclk times, then wait 32 ns plus dwell_ns before deselecting
  task automatic frame(input logic [15:0] word, input int nclk, input int dwell_ns);
    cs_n_out = 1'b0;
    sdi_out = word[15];
    // 64 ns period keeps the run short; a real master stays at or below 4.5 MHz
    for (int i = 0; i < nclk; i++) begin
      #32 sck_out = 1'b1;
      rd_word = {rd_word[14:0], line_w};
      last_r = line_w;
      #32 sck_out = 1'b0;
      sdi_out = word[(30 - i) % 16];
    end
    #(32 + dwell_ns) cs_n_out = 1'b1;        // clock stays low at deselect
  endtask : frame
endmodule : scfp_master
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import scfp_pkg::*;
  localparam int TOC = 50;  // short timeout keeps the run brief
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b1;  // dropped just after start so the reset edge is seen
  logic        standby_in = 1'b0;
  logic        fault_clear_in = 1'b0;
  logic [4:0]  status_in = 5'h00;
  logic [7:0]  payload_in = 8'h00;
  logic [31:0] seed = 32'h0170e4e6;
  logic        sdo_out, sdo_oe_n_out, frame_valid_out, ff, se;
  logic [1:0]  op;
  logic [5:0]  ad;
  logic [7:0]  dt;
  wire logic   sck_w, cs_n_w, sdi_w;
  int          n_fail = 0;
  int          tests_run = 0;
  int          bad[3] = '{1, 15, 17};
  logic [15:0] exp_q[$];
  always #20 clk_in = ~clk_in;
  scfp_port #(.TIMEOUT_CYC(TOC)) i_scfp_port (.clk_in, .rst_n_in, .sck_in(sck_w), .cs_n_in(cs_n_w),
    .sdi_in(sdi_w), .standby_in, .status_in, .payload_in, .fault_clear_in, .sdo_out, .sdo_oe_n_out,
    .frame_valid_out, .frame_opcode_out(op), .frame_addr_out(ad), .frame_data_out(dt),
    .frame_fault_flag_out(ff), .serial_error_flag_out(se));
  scfp_master i_scfp_master (.sck_out(sck_w), .cs_n_out(cs_n_w), .sdi_out(sdi_w), .sdo_in(sdo_out),
    .sdo_oe_n_in(sdo_oe_n_out));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one frame; ok says whether a word is delivered and read back
  task automatic run(input logic [15:0] w, input int n, input int dwell, input logic ok, input logic err);
    logic [6:0] low;
    repeat (5) @(posedge clk_in);
    #1 low = {status_in[4], err, 1'b0, status_in[3:0]};
    if (ok) exp_q.push_back(w);
    i_scfp_master.frame(w, n, dwell);
    if (ok) check(i_scfp_master.rd_word, {~|low, low, payload_in});
    repeat (10) @(posedge clk_in);
    #1;
  endtask : run
  // pulse the clear so the next fault check starts from a dropped flag
  task automatic clear_fault;
    fault_clear_in = 1'b1;
    @(posedge clk_in);
    #1 fault_clear_in = 1'b0;
    check({15'h0000, ff}, 16'h0000);
  endtask : clear_fault
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // delivered words are taken off the queue as the port reports them
  always @(negedge clk_in) begin
    if (frame_valid_out === 1'b1) check({op, ad, dt}, exp_q.size() ? exp_q.pop_front() : ~{op, ad, dt});
  end
  initial begin
    #1 rst_n_in = 1'b0;
    repeat (20) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      status_in = seed[12:8] & {5{seed[13]}};
      payload_in = seed[23:16];
      run(seed[31:16] ^ seed[15:0], 16, 0, 1'b1, 1'b0);
    end
    // each bad count starts from a cleared fault so the flag is really set again
    foreach (bad[k]) begin
      clear_fault();
      run(16'h5a5a, bad[k], 0, 1'b0, 1'b0);
      check({14'h0000, ff, se}, 16'h0003);
      run(16'h8001, 16, 0, 1'b1, 1'b1);
      check({15'h0000, se}, 16'h0000);
    end
    // select held past the limit after a full frame: word dropped
    clear_fault();
    run(16'h4321, 16, (TOC + 10) * 40, 1'b0, 1'b0);
    check({14'h0000, ff, se}, 16'h0003);
    run(16'h0c3f, 16, 0, 1'b1, 1'b1);
    // clockless frame held long enough to be seen: accepted, nothing changes
    run(16'hffff, 0, 200, 1'b0, 1'b0);
    check({15'h0000, se}, 16'h0000);
    clear_fault();
    standby_in = 1'b1;
    run(16'h1234, 16, 0, 1'b0, 1'b0);
    check({14'h0000, ff, se}, 16'h0000);
    standby_in = 1'b0;
    run(16'hc0de, 16, 0, 1'b1, 1'b0);
    check(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
  // about 30 us of frames expected; over six times that means a hang
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
